// ### rtl/spp_cfg.svh
// register offsets, field positions, reset values and timing for the serial port
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SPP_OFS_CTRL      8'h30
`define SPP_OFS_DATA      8'h38
`define SPP_OFS_MODE      8'h34
// ----------------------------------------
// control register fields
// ----------------------------------------
`define SPP_B_DONE        0
`define SPP_B_WRITE_COLLISION_FLAG        1
`define SPP_B_CHIP_SELECT_ENABLE        2
`define SPP_B_ORDER       3
`define SPP_B_EN          4
`define SPP_B_RLO         5
`define SPP_B_RHI         6
`define SPP_B_CKS         7
`define SPP_CTRL_RST      8'h60
// ----------------------------------------
// mode-control register fields
// ----------------------------------------
`define SPP_B_CLOCK_POLARITY        4
`define SPP_B_WGATE       5
`define SPP_B_SGATE       6
`define SPP_MODE_RST      8'h00
`define SPP_MODE_WMASK    8'h7F
// ----------------------------------------
// timing
// ----------------------------------------
`define SPP_BITS          8
`endif

// ### rtl/spp_pkg.sv
// types shared by the serial peripheral port
package spp_pkg;
	// transfer sequencer states
	typedef enum logic [1:0] {
		SPP_IDLE,
		SPP_RUN,
		SPP_DONE
	} spp_state_t;
endpackage

// ### rtl/spp_top.sv
// byte-wide serial peripheral port, master or slave, with apb registers
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "spp_cfg.svh"

// Contract
// - mode codes 00, 01, 10 select master
// - code 11 is slave; clock source ignored
// - master: data write loads buffer, starts transfer
// - slave: loaded buffer shifts on external clock
// - data write during transfer ignored, collision set
// - collision flag works only when gate set
// - hardware sets collision flag, software clears
// - transfers continue while processor halted
// - mode bit 4 selects clock polarity
// - polarity one follows inverted clock
// - bit order chooses msb or lsb first
// - with chip select on, slave shifts only while it is low
// - chip select disabled leaves pin floating
// - mode bit 6 gates chip select enable
// - idle pin levels per enable and role
// - port disabled floats pins, clears flags
// - done sets flag and interrupt, software clears
// - mode bits 0-3 stored and exported
// - mode bit 7 reads zero
// - clock select: half or full system clock
// - master rate base/2, base/4, base/16
// - order one msb first, zero lsb first
module spp_top
	import spp_pkg::*;
#(
	parameter int DATA_W = `SPP_BITS     // bits per transfer
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        chip_select_pin_i,
	output logic             chip_select_pin_o,
	output logic             chip_select_pin_oe,
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin_o,
	output logic             serial_out_pin_oe,
	output logic             serial_done_interrupt,
	output logic             left_dac_disable,
	output logic             right_dac_disable,
	output logic             adc_power_down,
	output logic             play_rate_select
);
	import spp_pkg::*;

	initial begin
		if (DATA_W != 8)
			$error("spp_top: only 8-bit transfers supported");
	end

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0]  ctrl_r;          // serial_bus_control
	logic [7:0]  mode_r;          // serial_mode_control
	logic [7:0]  data_r;          // serial_bus_data, readable copy
	logic [7:0]  shift_buffer;    // transmit/receive shift register
	spp_state_t  state_r;         // sequencer state
	logic [3:0]  bit_cnt_r;       // bits completed
	logic [4:0]  div_r;           // bit-rate divider
	logic        phase_r;         // second half of a bit period
	logic        sck_int_r;       // master clock, true phase
	logic        sin_r;           // sampled input bit
	logic        sck_q_r;         // previous slave clock level

	// ----------------------------------------
	// decoded controls
	// ----------------------------------------
	logic        en;              // port enabled
	logic        slave;           // role code 11
	logic        cs_on;           // chip select effective
	logic        clock_polarity;            // clock polarity
	logic        write_collision_flag_on;         // collision feature
	logic        msb_first;       // bit order
	logic [1:0]  rate;            // role/rate code
	logic        busy;            // transfer running
	logic        wr_en;           // apb write completes
	logic        data_wr;         // write to data register
	logic        ctrl_wr;         // write to control register
	logic        tick;            // one half-bit step
	logic        base_en;         // base clock enable
	logic [4:0]  half_len;        // base cycles per half bit, less one

	assign en        = ctrl_r[`SPP_B_EN];
	assign rate      = {ctrl_r[`SPP_B_RHI], ctrl_r[`SPP_B_RLO]};
	assign slave     = (rate == 2'b11);
	assign cs_on     = ctrl_r[`SPP_B_CHIP_SELECT_ENABLE] & mode_r[`SPP_B_SGATE];
	assign clock_polarity      = mode_r[`SPP_B_CLOCK_POLARITY];
	assign write_collision_flag_on   = mode_r[`SPP_B_WGATE];
	assign msb_first = ctrl_r[`SPP_B_ORDER];
	assign busy      = (state_r == SPP_RUN);
	assign wr_en     = psel & penable & pwrite;
	assign data_wr   = wr_en & (paddr == `SPP_OFS_DATA);
	assign ctrl_wr   = wr_en & (paddr == `SPP_OFS_CTRL);

	// apb answers in the access cycle, no wait states
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok(paddr);

	// one place decodes the legal offsets
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == `SPP_OFS_CTRL) || (a == `SPP_OFS_DATA) ||
		          (a == `SPP_OFS_MODE);
	endfunction

	// half-bit period in base cycles, less one, for the master rates
	always_comb begin
		unique case (rate)
			2'b00:   half_len = 5'd0;   // base/2, see note
			2'b01:   half_len = 5'd1;   // base/4
			default: half_len = 5'd7;   // base/16
		endcase
	end

	// ----------------------------------------
	// base clock divider
	// ----------------------------------------
	// system/2 when clock select is 0, full clock otherwise
	logic half_r;                     // toggle for system/2
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			half_r <= 1'b0;
		else
			half_r <= ~half_r;
	end
	assign base_en = ctrl_r[`SPP_B_CKS] | half_r;

	// half-bit tick; base rate toggles once per base enable,
	// so full base rate yields a bit every two base enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_r <= 5'd0;
		else if (!busy || !base_en)
			div_r <= busy ? div_r : 5'd0;
		else if (div_r >= half_len)
			div_r <= 5'd0;
		else
			div_r <= div_r + 5'd1;
	end
	assign tick = busy & ~slave & base_en & (div_r >= half_len);

	// ----------------------------------------
	// slave clock edges
	// ----------------------------------------
	logic s_lead;                     // leading edge of a bit
	logic s_trail;                    // trailing edge of a bit
	logic s_clk;                      // slave clock, polarity applied
	assign s_clk = sck_i ^ clock_polarity;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sck_q_r <= 1'b0;
		else
			sck_q_r <= s_clk;
	end
	// slave only shifts while selected when chip select is on
	logic sel_ok;
	assign sel_ok  = ~cs_on | ~chip_select_pin_i;
	assign s_lead  = busy & slave & sel_ok & s_clk & ~sck_q_r;
	assign s_trail = busy & slave & sel_ok & ~s_clk & sck_q_r;

	// unified shift strobes for both roles
	logic samp;                       // take the input bit
	logic shft;                       // advance to next bit
	assign samp = slave ? s_lead  : (tick & ~phase_r);
	assign shft = slave ? s_trail : (tick & phase_r);

	// ----------------------------------------
	// control register and flags
	// ----------------------------------------
	// flags set by hardware win over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `SPP_CTRL_RST;
		end else begin
			if (ctrl_wr) begin
				ctrl_r[7:2] <= pwdata[7:2];
				// software may only clear the flags
				if (!pwdata[`SPP_B_WRITE_COLLISION_FLAG])
					ctrl_r[`SPP_B_WRITE_COLLISION_FLAG] <= 1'b0;
				if (!pwdata[`SPP_B_DONE])
					ctrl_r[`SPP_B_DONE] <= 1'b0;
			end
			if (data_wr && busy && write_collision_flag_on && en)
				ctrl_r[`SPP_B_WRITE_COLLISION_FLAG] <= 1'b1;
			if (state_r == SPP_DONE)
				ctrl_r[`SPP_B_DONE] <= 1'b1;
			if (busy)
				ctrl_r[`SPP_B_DONE] <= 1'b0;
			if (!en && !(ctrl_wr && pwdata[`SPP_B_EN])) begin
				ctrl_r[`SPP_B_WRITE_COLLISION_FLAG] <= 1'b0;
				ctrl_r[`SPP_B_DONE] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// mode-control register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_r <= `SPP_MODE_RST;
		else if (wr_en && paddr == `SPP_OFS_MODE)
			mode_r <= pwdata[7:0] & `SPP_MODE_WMASK;
	end
	assign left_dac_disable  = mode_r[0];
	assign right_dac_disable = mode_r[1];
	assign adc_power_down    = mode_r[2];
	assign play_rate_select  = mode_r[3];

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	// runs on pclk only; halting the processor does not stop it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= SPP_IDLE;
		end else if (!en) begin
			state_r <= SPP_IDLE;
		end else begin
			unique case (state_r)
				SPP_IDLE:
					if (data_wr)
						state_r <= SPP_RUN;
				SPP_RUN:
					if (shft && bit_cnt_r == 4'd7)
						state_r <= SPP_DONE;
				SPP_DONE:
					state_r <= SPP_IDLE;
			endcase
		end
	end

	// half-bit phase of the master clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase_r <= 1'b0;
		else if (!busy)
			phase_r <= 1'b0;
		else if (tick)
			phase_r <= ~phase_r;
	end

	// master clock level, true phase: active level in second half
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sck_int_r <= 1'b0;
		else if (!busy)
			sck_int_r <= 1'b0;
		else if (tick)
			sck_int_r <= ~phase_r;
	end

	// next clock level feeds the pin, so the pin edge and the
	// internal sample strobe land together instead of a cycle apart
	logic sck_int_nxt;                // master clock, next level
	assign sck_int_nxt = !busy ? 1'b0 : (tick ? ~phase_r : sck_int_r);

	// bit counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bit_cnt_r <= 4'd0;
		else if (!busy)
			bit_cnt_r <= 4'd0;
		else if (shft)
			bit_cnt_r <= bit_cnt_r + 4'd1;
	end

	// input sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sin_r <= 1'b0;
		else if (samp)
			sin_r <= serial_in_pin;
	end

	// ----------------------------------------
	// shift buffer and readable data
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_buffer <= 8'h00;
		end else if (data_wr && !busy && en) begin
			shift_buffer <= pwdata[7:0];
		end else if (shft) begin
			if (msb_first)
				shift_buffer <= {shift_buffer[6:0], sin_r};
			else
				shift_buffer <= {sin_r, shift_buffer[7:1]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data_r <= 8'h00;
		else if (state_r == SPP_DONE)
			data_r <= shift_buffer;
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	logic out_bit;
	assign out_bit = msb_first ? shift_buffer[7] : shift_buffer[0];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_out_pin_o   <= 1'b1;
			serial_out_pin_oe  <= 1'b0;
			sck_o              <= 1'b0;
			sck_oe             <= 1'b0;
			chip_select_pin_o  <= 1'b1;
			chip_select_pin_oe <= 1'b0;
		end else begin
			serial_out_pin_oe  <= en;
			serial_out_pin_o   <= busy ? out_bit : 1'b1;
			sck_oe             <= en & ~slave;
			sck_o              <= sck_int_nxt ^ clock_polarity;
			chip_select_pin_oe <= en & cs_on & ~slave;
			// select falls on the start write, at least a cycle ahead of the clock
			chip_select_pin_o  <= ~(busy | (data_wr & en));
		end
	end

	assign serial_done_interrupt = ctrl_r[`SPP_B_DONE];

	// ----------------------------------------
	// apb read data
	// ----------------------------------------
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			`SPP_OFS_CTRL: prdata[7:0] = ctrl_r;
			`SPP_OFS_DATA: prdata[7:0] = data_r;
			`SPP_OFS_MODE: prdata[7:0] = mode_r;
			default:       prdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_write_collision_flag_set;
		@(posedge pclk) disable iff (!presetn)
		(data_wr && busy && write_collision_flag_on && en) |=> ctrl_r[`SPP_B_WRITE_COLLISION_FLAG];
	endproperty
	a_write_collision_flag_set: assert property (p_write_collision_flag_set) else $error("collision lost");

	property p_write_collision_flag_gate;
		@(posedge pclk) disable iff (!presetn)
		(!write_collision_flag_on && !ctrl_r[`SPP_B_WRITE_COLLISION_FLAG]) |=> !ctrl_r[`SPP_B_WRITE_COLLISION_FLAG];
	endproperty
	a_write_collision_flag_gate: assert property (p_write_collision_flag_gate) else $error("collision ungated");

	property p_write_collision_flag_hold;
		@(posedge pclk) disable iff (!presetn)
		(ctrl_r[`SPP_B_WRITE_COLLISION_FLAG] && !ctrl_wr && en) |=> ctrl_r[`SPP_B_WRITE_COLLISION_FLAG];
	endproperty
	a_write_collision_flag_hold: assert property (p_write_collision_flag_hold) else $error("collision self-cleared");

	property p_done_set;
		@(posedge pclk) disable iff (!presetn)
		(state_r == SPP_DONE) |=> serial_done_interrupt;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done not raised");

	property p_done_low_busy;
		@(posedge pclk) disable iff (!presetn)
		$rose(busy) |=> !ctrl_r[`SPP_B_DONE];
	endproperty
	a_done_low_busy: assert property (p_done_low_busy) else $error("done during run");

	property p_disabled_float;
		@(posedge pclk) disable iff (!presetn)
		(!en && $past(!en)) |-> !(sck_oe | serial_out_pin_oe | chip_select_pin_oe);
	endproperty
	a_disabled_float: assert property (p_disabled_float) else $error("pin driven");

	property p_mode7;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |-> !mode_r[7];
	endproperty
	a_mode7: assert property (p_mode7) else $error("mode bit7 set");

	property p_cs_gate;
		@(posedge pclk) disable iff (!presetn)
		!mode_r[`SPP_B_SGATE] |=> !chip_select_pin_oe;
	endproperty
	a_cs_gate: assert property (p_cs_gate) else $error("select ungated");

	property p_slave_no_clk;
		@(posedge pclk) disable iff (!presetn)
		slave |=> !sck_oe;
	endproperty
	a_slave_no_clk: assert property (p_slave_no_clk) else $error("slave drives clock");

	property p_idle_out_high;
		@(posedge pclk) disable iff (!presetn)
		(en && !busy) |=> serial_out_pin_o;
	endproperty
	a_idle_out_high: assert property (p_idle_out_high) else $error("idle out low");

endmodule // spp_top
`default_nettype wire

// ### testbench/spp_far_end.sv
// far-end serial model: listens as a slave or masters the clock itself
`timescale 1ns/1ps
`default_nettype none
module spp_far_end (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       sck,      // resolved clock line
	input  wire logic       cs_n,     // resolved select line
	input  wire logic       ser_out,  // device data out
	input  wire logic       ser_oe,   // device drives data out
	input  wire logic       pol,      // idle level of the clock
	input  wire logic       msb,      // most significant bit first
	input  wire logic       load,     // start a fresh byte
	input  wire logic       run,      // make the clock ourselves
	input  wire logic       sel,      // pull select low while running
	input  wire logic [7:0] tx,       // byte we send
	output logic            ser_in,   // our data toward the device
	output logic            sck_drv,  // our clock when running
	output logic            cs_drv_n, // our select when running
	output logic [7:0]      rx,       // byte we received
	output logic [3:0]      edges,    // leading edges seen
	output logic            cs_lead,  // select level at a leading edge
	output int              per       // cycles between leading edges
);
	logic       sck_q;  // clock seen last cycle
	logic       hold;   // churns so a released line never looks valid
	logic       lead;   // clock leaves its idle level
	logic       trail;  // clock returns to idle
	logic       bit_in; // what the data-out line shows
	logic [3:0] cnt;    // bits sent
	logic [3:0] ph;     // half-period timer
	logic [4:0] ntog;   // clock toggles made
	int         cyc;    // cycles since last leading edge
	// ------------------------------------------------
	// edges and line levels
	// ------------------------------------------------
	assign lead     = sck_q == pol && sck == !pol;
	assign trail    = sck_q == !pol && sck == pol;
	assign bit_in   = ser_oe ? ser_out : hold;
	// the next bit appears as soon as the trailing edge is seen
	logic [3:0] nb;     // index of the bit now presented
	assign nb       = cnt + {3'h0, trail};
	assign ser_in   = nb < 4'h8 ? tx[msb ? 3'h7 - nb[2:0] : nb[2:0]] : hold;
	assign cs_drv_n = ~(run & sel);
	// ------------------------------------------------
	// sample on leading edges, advance on trailing
	// ------------------------------------------------
	always_ff @(posedge pclk) begin
		sck_q <= sck;
		hold  <= presetn ? ~hold : 1'b0;
		if (!presetn || load) begin
			cnt   <= presetn ? 4'h0 : 4'h8;
			edges <= 4'h0;
			rx    <= 8'h00;
			cyc   <= 0;
		end else begin
			cyc <= lead ? 1 : cyc + 1;
			if (lead) begin
				rx      <= msb ? {rx[6:0], bit_in} : {bit_in, rx[7:1]};
				edges   <= edges + 4'h1;
				per     <= cyc;
				cs_lead <= cs_n;
			end
			if (trail)
				cnt <= cnt + 4'h1;
		end
	end
	// ------------------------------------------------
	// clock maker: four cycles a half period, still between frames
	// ------------------------------------------------
	always_ff @(posedge pclk) begin
		if (!run) begin
			ph      <= 4'h0;
			ntog    <= 5'h00;
			sck_drv <= pol;
		end else if (ntog < 5'h10) begin
			ph <= ph == 4'h3 ? 4'h0 : ph + 4'h1;
			if (ph == 4'h3) begin
				sck_drv <= ~sck_drv;
				ntog    <= ntog + 5'h01;
			end
		end
	end
endmodule // spp_far_end
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
`include "spp_cfg.svh"
module tb;
	import spp_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        err, pready, pslverr, sck_o, sck_oe, cs_o, cs_oe, so, so_oe;
	logic        irq, sck_w, cs_w, ser_in, sck_drv, cs_drv_n, cs_lead;
	logic [3:0]  aud, f_edges;
	logic        f_pol = 1'b0, f_msb = 1'b0, f_load = 1'b0, sel_en = 1'b0;
	logic        f_run = 1'b0, f_sel = 1'b0;
	logic [7:0]  f_tx = 8'h00, f_rx;
	int          f_per, fail_count = 0, n_checks = 0, cyc = 0;
	// ------------------------------------------------
	// clock, shared lines, instances
	// ------------------------------------------------
	always #50 pclk = ~pclk;
	assign sck_w = sck_oe ? sck_o : sck_drv;
	assign cs_w  = cs_oe ? cs_o : cs_drv_n;
	spp_top spp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_i(sck_w),
		.sck_o(sck_o), .sck_oe(sck_oe), .chip_select_pin_i(cs_w),
		.chip_select_pin_o(cs_o), .chip_select_pin_oe(cs_oe),
		.serial_in_pin(ser_in), .serial_out_pin_o(so),
		.serial_out_pin_oe(so_oe), .serial_done_interrupt(irq),
		.left_dac_disable(aud[0]), .right_dac_disable(aud[1]),
		.adc_power_down(aud[2]), .play_rate_select(aud[3]));
	spp_far_end spp_far_end_i (.pclk(pclk), .presetn(presetn), .sck(sck_w),
		.cs_n(cs_w), .ser_out(so), .ser_oe(so_oe), .pol(f_pol), .msb(f_msb),
		.load(f_load), .run(f_run), .sel(f_sel), .tx(f_tx), .ser_in(ser_in),
		.sck_drv(sck_drv), .cs_drv_n(cs_drv_n), .rx(f_rx), .edges(f_edges),
		.cs_lead(cs_lead), .per(f_per));
	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; waits for pready, never assumes a count
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 20)
			fail_count++;
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic far_load(input logic [7:0] b, input logic o);
		f_tx <= b; f_msb <= o; f_load <= 1'b1;
		@(posedge pclk);
		f_load <= 1'b0;
	endtask
	task automatic wait_irq(input int lim);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < lim) begin
			@(posedge pclk);
			k++;
		end
		chk(irq, 1'b1);
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic t_regs;
		chk({sck_oe, cs_oe, so_oe, irq}, 4'h0);
		apb(1'b0, `SPP_OFS_CTRL, 8'h00); chk(r, 32'h60);
		apb(1'b0, `SPP_OFS_MODE, 8'h00); chk(r, 32'h0);
		apb(1'b0, 8'h33, 8'h00); chk({err, r[7:0]}, 9'h100);
		apb(1'b1, `SPP_OFS_MODE, 8'hFF);
		apb(1'b0, `SPP_OFS_MODE, 8'h00); chk(r, 32'h7F);
		chk(aud, 4'hF);
		apb(1'b1, `SPP_OFS_MODE, 8'h00);
		chk(aud, 4'h0);
		apb(1'b1, `SPP_OFS_CTRL, 8'hB3);
		repeat (2) @(posedge pclk);
		chk({sck_oe, sck_o, so_oe, so, cs_oe}, 5'h16);
	endtask
	// master byte: ck is clock select and rate code
	task automatic m_xfer(input logic [2:0] ck, input logic o, input int per,
			input logic [7:0] mine, input logic [7:0] them);
		apb(1'b1, `SPP_OFS_CTRL, {ck, 1'b1, o, sel_en, 2'h3});
		far_load(them, o);
		apb(1'b1, `SPP_OFS_DATA, mine);
		apb(1'b0, `SPP_OFS_CTRL, 8'h00); chk(r[0], 1'b0);
		wait_irq(400);
		chk(f_rx, mine);
		chk(f_edges, 4'h8);
		chk(f_per, per);
		apb(1'b0, `SPP_OFS_DATA, 8'h00); chk(r, {24'h0, them});
		apb(1'b1, `SPP_OFS_CTRL, {ck, 1'b1, o, sel_en, 2'h2});
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
	endtask
	task automatic t_rates;
		m_xfer(3'h4, 1'b1, 2, 8'hA5, 8'h5A);
		m_xfer(3'h5, 1'b0, 4, 8'h81, 8'h37);
		m_xfer(3'h6, 1'b1, 16, 8'h6E, 8'hC1);
		m_xfer(3'h1, 1'b0, 8, 8'h0F, 8'hF0);
	endtask
	// second data write in mid-transfer, gate g on the collision flag
	task automatic t_coll(input logic g);
		apb(1'b1, `SPP_OFS_MODE, {2'h0, g, 5'h00});
		apb(1'b1, `SPP_OFS_CTRL, 8'hDB);
		far_load(8'h00, 1'b1);
		apb(1'b1, `SPP_OFS_DATA, 8'h3C);
		apb(1'b1, `SPP_OFS_DATA, 8'hC3);
		apb(1'b0, `SPP_OFS_CTRL, 8'h00); chk(r[1], g);
		wait_irq(400);
		chk(f_rx, 8'h3C);
		apb(1'b0, `SPP_OFS_CTRL, 8'h00); chk(r[1:0], {g, 1'b1});
		apb(1'b1, `SPP_OFS_CTRL, 8'hD8);
		apb(1'b0, `SPP_OFS_CTRL, 8'h00); chk(r, 32'hD8);
	endtask
	task automatic t_pol_sel;
		apb(1'b1, `SPP_OFS_MODE, 8'h50);
		f_pol <= 1'b1;
		sel_en = 1'b1;
		apb(1'b1, `SPP_OFS_CTRL, 8'hB7);
		repeat (2) @(posedge pclk);
		chk({sck_oe, sck_o, cs_oe, cs_o}, 4'hF);
		m_xfer(3'h5, 1'b1, 4, 8'hE1, 8'h1E);
		chk(cs_lead, 1'b0);
		apb(1'b1, `SPP_OFS_MODE, 8'h10);
		repeat (2) @(posedge pclk);
		chk(cs_oe, 1'b0);
	endtask
	task automatic t_slave;
		apb(1'b1, `SPP_OFS_MODE, 8'h40);
		f_pol <= 1'b0;
		apb(1'b1, `SPP_OFS_CTRL, 8'h7F);
		far_load(8'h96, 1'b1);
		apb(1'b1, `SPP_OFS_DATA, 8'h2B);
		f_sel <= 1'b1;
		f_run <= 1'b1;
		wait_irq(300);
		chk({sck_oe, f_rx}, 9'h02B);
		f_run <= 1'b0;
		apb(1'b0, `SPP_OFS_DATA, 8'h00); chk(r, 32'h96);
		apb(1'b1, `SPP_OFS_CTRL, 8'h7C);
		far_load(8'h55, 1'b1);
		apb(1'b1, `SPP_OFS_DATA, 8'hA1);
		f_sel <= 1'b0;
		f_run <= 1'b1;
		repeat (100) @(posedge pclk);
		chk(irq, 1'b0);
		f_run <= 1'b0;
		apb(1'b1, `SPP_OFS_CTRL, 8'h00);
		repeat (2) @(posedge pclk);
		chk({sck_oe, cs_oe, so_oe, irq}, 4'h0);
		apb(1'b0, `SPP_OFS_CTRL, 8'h00); chk(r, 32'h0);
	endtask
	// ------------------------------------------------
	// verdict, hang guard, main sequence
	// ------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_rates();
		t_coll(1'b1);
		t_coll(1'b0);
		t_pol_sel();
		t_slave();
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
